// ===== logic/nmtc_top.sv
// Nested memory type combiner: attribute tables, entry merge and walk helpers.
// Assumes the table walker presents entry fields with a one-cycle write strobe
// and that all inputs are on the mclk domain.
`timescale 1ns/100ps
`default_nettype none
module nmtc_top
(
  input  wire logic                         mclk,                  // Core clock.
  input  wire logic                         rstn,                  // Async reset, active low.
  input  wire logic                         nested_on,             // Nested translation enabled.
  input  wire logic                         guest_entry_operation, // Guest entry pulse.
  input  wire logic                         guest_exit_operation,  // Guest exit pulse.
  input  wire logic [nmtc_pkg::ATTR_W-1:0]  control_block_attr,    // Guest attribute table field.
  input  wire logic                         attr_write,            // Attribute write pulse: host table when nested is off, guest table when on.
  input  wire logic [nmtc_pkg::ATTR_W-1:0]  attr_write_data,       // Value for that write.
  input  wire logic                         guest_cache_disable,   // Guest cache disable.
  input  wire logic                         host_cache_disable,    // Host cache disable.
  input  wire logic [1:0]                   guest_base_bits,       // Guest base {cache off, wt}.
  input  wire logic [1:0]                   nested_base_bits,      // Nested base {cache off, wt}.
  input  wire logic [2:0]                   guest_entry_bits,      // Guest entry {attr, off, wt}.
  input  wire logic [2:0]                   nested_entry_bits,     // Nested entry {attr, off, wt}.
  input  wire logic                         guest_leaf_is_table,   // Type from guest base bits.
  input  wire logic                         nested_leaf_is_table,  // Type from nested base bits.
  input  wire logic [2:0]                   range_type_register,   // Range type of system address.
  input  wire logic [nmtc_pkg::PADDR_W-1:0] sys_addr,              // Final system address.
  input  wire logic [nmtc_pkg::PAGE_W-1:0]  guest_page_size,       // Guest page size code.
  input  wire logic [nmtc_pkg::PAGE_W-1:0]  nested_page_size,      // Nested page size code.
  input  wire logic                         entry_write,           // Entry write strobe.
  input  wire logic                         pdp_read_valid,        // Pointer entry fetched.
  input  wire logic [nmtc_pkg::PDP_W-1:0]   pdp_read_data,         // That pointer entry.
  output var  logic [nmtc_pkg::ATTR_W-1:0]  page_attribute_table,  // Host attribute table.
  output var  logic [nmtc_pkg::ATTR_W-1:0]  guest_attribute_table, // Guest attribute table.
  output var  logic                         entry_valid,           // Entry captured pulse.
  output var  nmtc_pkg::nmtc_type_t         entry_type,            // Captured effective type.
  output var  logic                         entry_snoop_all,       // Captured snoop-all flag.
  output var  logic                         entry_combine,         // Captured combining flag.
  output var  logic [nmtc_pkg::PAGE_W-1:0]  entry_page_size,       // Captured page size.
  output var  logic [nmtc_pkg::PADDR_W-1:0] entry_sys_addr,        // Captured unmasked address.
  output var  logic                         wc_flush,              // Write combiner flush pulse.
  output var  logic                         pdp_fault              // Illegal pointer entry pulse.
);
  import nmtc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Attribute tables.

  logic [ATTR_W-1:0] host_q;
  logic [ATTR_W-1:0] guest_q;

  wire host_wr  = attr_write & ~nested_on;
  wire guest_wr = attr_write & nested_on;
  wire load_cb  = guest_entry_operation & nested_on;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      host_q  <= ATTR_RESET;
      guest_q <= ATTR_RESET;
    end
    else
    begin
      if (host_wr)
        host_q <= attr_write_data;
      if (load_cb)
        guest_q <= control_block_attr;
      else if (guest_wr)
        guest_q <= attr_write_data;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      page_attribute_table  <= ATTR_RESET;
      guest_attribute_table <= ATTR_RESET;
    end
    else
    begin
      page_attribute_table  <= host_q;
      guest_attribute_table <= guest_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table index selection from base register or entry bits.

  wire [2:0] g_idx = guest_leaf_is_table ? {1'b0, guest_base_bits} : guest_entry_bits;
  wire [2:0] h_idx = nested_leaf_is_table ? {1'b0, nested_base_bits} : nested_entry_bits;
  wire [ATTR_ENTRY-1:0] g_ent = guest_q[g_idx*ATTR_ENTRY +: ATTR_ENTRY];
  wire [ATTR_ENTRY-1:0] h_ent = host_q[h_idx*ATTR_ENTRY +: ATTR_ENTRY];

  nmtc_if lk();

  assign lk.nested_on           = nested_on;
  assign lk.guest_raw           = g_ent[2:0];
  assign lk.host_raw            = h_ent[2:0];
  // Range lookup uses only the final system address; no guest range set exists.
  assign lk.range_raw           = range_type_register;
  assign lk.guest_cache_disable = guest_cache_disable;
  assign lk.host_cache_disable  = host_cache_disable;

  nmtc_merge u_merge
  (
    .m (lk.merge)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Entry capture.

  // Smaller code means smaller page; guest size alone when nested is off.
  wire [PAGE_W-1:0] size_d = (!nested_on) ? guest_page_size
                           : (guest_page_size < nested_page_size) ? guest_page_size
                           : nested_page_size;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      entry_valid     <= 1'b0;
      entry_type      <= NMTC_UC;
      entry_snoop_all <= 1'b0;
      entry_combine   <= 1'b0;
      entry_page_size <= '0;
      entry_sys_addr  <= '0;
    end
    else
    begin
      entry_valid <= entry_write;
      if (entry_write)
      begin
        entry_type      <= lk.result;
        entry_snoop_all <= lk.snoop_all;
        entry_combine   <= lk.combine_writes;
        entry_page_size <= size_d;
        entry_sys_addr  <= sys_addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flush and pointer entry checks.

  // Pointer entries are never cached here; each walk read in nested mode is checked as it
  // arrives, so nothing is flagged when the table base is written.
  wire pdp_bad = pdp_read_valid & pdp_read_data[PDP_VALID] &
                 (|(pdp_read_data & PDP_RSVD_MASK));

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      wc_flush  <= 1'b0;
      pdp_fault <= 1'b0;
    end
    else
    begin
      wc_flush  <= guest_entry_operation | guest_exit_operation;
      pdp_fault <= nested_on & pdp_bad;
    end
  end

endmodule
`default_nettype wire

// ===== logic/nmtc_pkg.sv
// Package for the nested memory type combiner: type encodings and table formats.
// Assumes attribute tables use eight 8-bit entries with the low three bits as the type.
package nmtc_pkg;

  // Memory type encodings as held in attribute table entries.
  localparam logic [2:0] MT_UC  = 3'h0;
  localparam logic [2:0] MT_WC  = 3'h1;
  localparam logic [2:0] MT_WT  = 3'h4;
  localparam logic [2:0] MT_WP  = 3'h5;
  localparam logic [2:0] MT_WB  = 3'h6;
  localparam logic [2:0] MT_UCM = 3'h7;

  // Effective types leaving the combiner, including the two extra kinds.
  typedef enum logic [2:0] {
    NMTC_UC, NMTC_UCM, NMTC_WC, NMTC_WCP, NMTC_WP, NMTC_WT, NMTC_WB, NMTC_CD
  } nmtc_type_t;

  localparam int ATTR_W      = 64;
  localparam int ATTR_ENTRY  = 8;
  localparam int PADDR_W     = 52;
  localparam int PAGE_W      = 2;
  localparam logic [63:0] ATTR_RESET = 64'h0007040600070406;
  localparam int PDP_W       = 64;
  localparam int PDP_VALID   = 0;
  localparam logic [63:0] PDP_RSVD_MASK = 64'h00000000000001E6;

endpackage

// ===== logic/nmtc_if.sv
// Interface carrying one attribute lookup between the top and the merge module.
// Assumes both ends sit on the single core clock.
`timescale 1ns/100ps
`default_nettype none
interface nmtc_if;
  import nmtc_pkg::*;
  logic       nested_on;
  logic [2:0] guest_raw;
  logic [2:0] host_raw;
  logic [2:0] range_raw;
  logic       guest_cache_disable;
  logic       host_cache_disable;
  nmtc_type_t result;
  logic       snoop_all;
  logic       combine_writes;
  modport top   (output nested_on, guest_raw, host_raw, range_raw, guest_cache_disable,
                 host_cache_disable, input result, snoop_all, combine_writes);
  modport merge (input nested_on, guest_raw, host_raw, range_raw, guest_cache_disable,
                 host_cache_disable, output result, snoop_all, combine_writes);
endinterface
`default_nettype wire

// ===== logic/nmtc_merge.sv
// Combinational merge of guest, host and range types into one effective type.
// Assumes raw encodings from attribute tables; unsupported codes are treated as UC.
`timescale 1ns/100ps
`default_nettype none
module nmtc_merge
(
  nmtc_if.merge m  // Lookup in, effective type out.
);
  import nmtc_pkg::*;

  function automatic nmtc_type_t decode(input logic [2:0] raw);
    case (raw)
      MT_UC:   decode = NMTC_UC;
      MT_WC:   decode = NMTC_WC;
      MT_WT:   decode = NMTC_WT;
      MT_WP:   decode = NMTC_WP;
      MT_WB:   decode = NMTC_WB;
      MT_UCM:  decode = NMTC_UCM;
      default: decode = NMTC_UC;
    endcase
  endfunction

  // Guest with host.
  function automatic nmtc_type_t gh(input nmtc_type_t g, input nmtc_type_t h);
    case (g)
      NMTC_UC:  gh = NMTC_UC;
      NMTC_UCM: gh = (h == NMTC_UCM) ? NMTC_UCM : (h == NMTC_WC) ? NMTC_WC : NMTC_UC;
      NMTC_WC:  gh = (h == NMTC_UC || h == NMTC_UCM || h == NMTC_WC) ? NMTC_WC
                     : NMTC_WCP;
      NMTC_WP:  gh = (h == NMTC_WP || h == NMTC_WB) ? NMTC_WP : NMTC_UC;
      NMTC_WT:  gh = (h == NMTC_WT || h == NMTC_WB) ? NMTC_WT : NMTC_UC;
      NMTC_WB:  gh = (h == NMTC_UCM) ? NMTC_UC : h;
      default:  gh = NMTC_UC;
    endcase
  endfunction

  // Combined type with range type.
  function automatic nmtc_type_t pr(input nmtc_type_t p, input nmtc_type_t r);
    case (p)
      NMTC_UC:  pr = (r == NMTC_UC) ? NMTC_UC : NMTC_CD;
      NMTC_UCM: pr = (r == NMTC_UC) ? NMTC_UC : (r == NMTC_WC) ? NMTC_WC : NMTC_CD;
      NMTC_WC:  pr = NMTC_WC;
      NMTC_WCP: pr = (r == NMTC_UC || r == NMTC_WC) ? NMTC_WC : NMTC_WCP;
      NMTC_WP:  pr = (r == NMTC_UC) ? NMTC_UC : (r == NMTC_WP || r == NMTC_WB) ? NMTC_WP
                     : NMTC_CD;
      NMTC_WT:  pr = (r == NMTC_UC) ? NMTC_UC : (r == NMTC_WT || r == NMTC_WB) ? NMTC_WT
                     : NMTC_CD;
      NMTC_WB:  pr = (r == NMTC_UCM) ? NMTC_UC : r;
      default:  pr = NMTC_UC;
    endcase
  endfunction

  wire nmtc_type_t g_t      = decode(m.guest_raw);
  wire nmtc_type_t h_t      = decode(m.host_raw);
  wire nmtc_type_t r_t      = decode(m.range_raw);
  // Off: guest table ignored entirely, host type alone meets the range type.
  wire nmtc_type_t combined = m.nested_on ? gh(g_t, h_t) : h_t;
  wire nmtc_type_t ranged   = pr(combined, r_t);
  wire             cd_any   = m.host_cache_disable | (m.nested_on & m.guest_cache_disable);
  // Cache disable keeps write combining and snooping types but stops caching.
  wire             cacheable = (ranged == NMTC_WB) || (ranged == NMTC_WT) || (ranged == NMTC_WP);

  assign m.result         = (cd_any && cacheable) ? NMTC_CD : ranged;
  assign m.combine_writes = (m.result == NMTC_WC) || (m.result == NMTC_WCP);
  assign m.snoop_all      = (m.result == NMTC_WCP) || (m.result == NMTC_CD);

endmodule
`default_nettype wire

// ===== sim/nmtc_tlb_model.sv
// Stand-in for the translation buffer: takes every entry the combiner hands over.
// Assumes one entry per cycle in which entry_valid is high.
`timescale 1ns/100ps
`default_nettype none
module nmtc_tlb_model
(
  input  wire logic mclk,        // Core clock.
  input  wire logic entry_valid, // Entry offered.
  output var  int   count        // Entries taken so far.
);
  always @(posedge mclk)
    if (entry_valid === 1'b1)
      count <= count + 1;
endmodule
`default_nettype wire

// ===== sim/nmtc_top_chk.sv
// Checker for the nested memory type combiner, bound to its top ports.
// Assumes one mclk domain and rstn as an asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module nmtc_top_chk
(
  input wire logic                         mclk,                  // Clock.
  input wire logic                         rstn,                  // Reset.
  input wire logic                         nested_on,             // Nested mode.
  input wire logic                         guest_entry_operation, // Entry pulse.
  input wire logic                         guest_exit_operation,  // Exit pulse.
  input wire logic [nmtc_pkg::PAGE_W-1:0]  guest_page_size,       // Guest size.
  input wire logic [nmtc_pkg::PAGE_W-1:0]  nested_page_size,      // Nested size.
  input wire logic [nmtc_pkg::PADDR_W-1:0] sys_addr,              // Address in.
  input wire logic                         entry_write,           // Entry strobe.
  input wire logic                         pdp_read_valid,        // Pointer read.
  input wire logic [nmtc_pkg::PDP_W-1:0]   pdp_read_data,         // Pointer data.
  input wire logic                         entry_valid,           // Entry out.
  input wire nmtc_pkg::nmtc_type_t         entry_type,            // Type out.
  input wire logic                         entry_snoop_all,       // Snoop out.
  input wire logic                         entry_combine,         // Combine out.
  input wire logic [nmtc_pkg::PAGE_W-1:0]  entry_page_size,       // Size out.
  input wire logic [nmtc_pkg::PADDR_W-1:0] entry_sys_addr,        // Address out.
  input wire logic                         wc_flush,              // Flush out.
  input wire logic                         pdp_fault              // Fault out.
);
  import nmtc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // With nested translation off there is no nested entry, so the guest size stands alone.
  wire logic [PAGE_W-1:0] psz_d = !nested_on ? guest_page_size
                                : guest_page_size < nested_page_size ? guest_page_size
                                : nested_page_size;
  wire logic       pdp_d = pdp_read_valid && nested_on && pdp_read_data[PDP_VALID]
                           && |(pdp_read_data & PDP_RSVD_MASK);
  a_entry_answer: assert property (entry_write |=> entry_valid) else $error("entry lost");
  a_entry_cause: assert property (entry_valid |-> $past(entry_write)) else $error("stray");
  a_flush_after: assert property (guest_entry_operation || guest_exit_operation |=> wc_flush)
    else $error("no flush");
  a_flush_cause: assert property (wc_flush |-> $past(guest_entry_operation)
    || $past(guest_exit_operation)) else $error("stray flush");
  a_page_small: assert property (entry_valid |-> entry_page_size == $past(psz_d))
    else $error("page size");
  a_addr_whole: assert property (entry_valid |-> entry_sys_addr == $past(sys_addr))
    else $error("address masked");
  a_pdp_walk: assert property (pdp_fault == $past(pdp_d)) else $error("pointer fault");
  a_snoop_kind: assert property (entry_valid |->
    entry_snoop_all == (entry_type inside {NMTC_WCP, NMTC_CD})) else $error("snoop flag");
  a_combine_kind: assert property (entry_valid |->
    entry_combine == (entry_type inside {NMTC_WC, NMTC_WCP})) else $error("combine flag");
  c_wcp: cover property (entry_valid && entry_type == NMTC_WCP);
  c_cd: cover property (entry_valid && entry_type == NMTC_CD);
  c_flush: cover property (wc_flush);
endmodule
bind nmtc_top nmtc_top_chk u_chk (.mclk, .rstn, .nested_on, .guest_entry_operation,
  .guest_exit_operation, .guest_page_size, .nested_page_size, .sys_addr, .entry_write,
  .pdp_read_valid, .pdp_read_data, .entry_valid, .entry_type, .entry_snoop_all, .entry_combine,
  .entry_page_size, .entry_sys_addr, .wc_flush, .pdp_fault);
`default_nettype wire

// ===== sim/nmtc_top_tb.sv
// Bench for the nested memory type combiner: tables, merges, flushes, walks.
// Assumes the design, the checker and the buffer model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module nmtc_top_tb;
  import nmtc_pkg::*;
  // Lanes 0..5 hold UC, UC-, WC, WP, WT, WB so an entry index names its type.
  localparam logic [63:0] TBL = 64'h0000060405010700;
  logic mclk, rstn, nested_on, guest_entry_operation, guest_exit_operation, attr_write;
  logic guest_cache_disable, host_cache_disable, entry_write, pdp_read_valid;
  logic entry_valid, wc_flush, pdp_fault;
  logic [63:0] control_block_attr, attr_write_data, pdp_read_data;
  logic [63:0] page_attribute_table, guest_attribute_table;
  logic [2:0] guest_entry_bits, nested_entry_bits, range_type_register;
  logic [1:0] guest_page_size, nested_page_size;
  logic [1:0] guest_base_bits, nested_base_bits;
  logic guest_leaf_is_table, nested_leaf_is_table;
  logic [51:0] sys_addr;
  nmtc_type_t entry_type;
  int error_cnt, n_tests, n_ent, n_buf;
  nmtc_type_t ty[6] = '{NMTC_UC, NMTC_UCM, NMTC_WC, NMTC_WP, NMTC_WT, NMTC_WB};
  nmtc_type_t rt[5] = '{NMTC_UC, NMTC_WC, NMTC_WP, NMTC_WT, NMTC_WB};
  logic [2:0] rc[5] = '{MT_UC, MT_WC, MT_WP, MT_WT, MT_WB};
  nmtc_top u_dut (.mclk, .rstn, .nested_on, .guest_entry_operation, .guest_exit_operation,
    .control_block_attr, .attr_write, .attr_write_data, .guest_cache_disable,
    .host_cache_disable, .guest_base_bits, .nested_base_bits, .guest_entry_bits,
    .nested_entry_bits, .guest_leaf_is_table, .nested_leaf_is_table,
    .range_type_register, .sys_addr, .guest_page_size, .nested_page_size, .entry_write,
    .pdp_read_valid, .pdp_read_data, .page_attribute_table, .guest_attribute_table,
    .entry_valid, .entry_type, .entry_snoop_all(), .entry_combine(), .entry_page_size(),
    .entry_sys_addr(), .wc_flush, .pdp_fault);
  nmtc_tlb_model u_buf (.mclk, .entry_valid, .count(n_buf));
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic nmtc_type_t gh(nmtc_type_t g, h);
    case (g)
      NMTC_UC: return NMTC_UC;
      NMTC_UCM: return h == NMTC_UCM || h == NMTC_WC ? h : NMTC_UC;
      NMTC_WC: return h <= NMTC_WC ? NMTC_WC : NMTC_WCP;
      NMTC_WB: return h == NMTC_UCM ? NMTC_UC : h;
      default: return h == g || h == NMTC_WB ? g : NMTC_UC;
    endcase
  endfunction
  function automatic nmtc_type_t pr(nmtc_type_t c, m, logic cd);
    nmtc_type_t t;
    case (c)
      NMTC_UC: t = m == NMTC_UC ? m : NMTC_CD;
      NMTC_UCM: t = m <= NMTC_WC ? m : NMTC_CD;
      NMTC_WC: t = NMTC_WC;
      NMTC_WCP: t = m <= NMTC_WC ? NMTC_WC : c;
      NMTC_WB: t = m;
      default: t = m == NMTC_UC ? m : m == c || m == NMTC_WB ? c : NMTC_CD;
    endcase
    return cd && t inside {NMTC_WP, NMTC_WT, NMTC_WB} ? NMTC_CD : t;
  endfunction
  task automatic chk(input logic [63:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Kind 0/1 writes the table with nested mode off/on, 2 is guest entry, 3 is exit.
  task automatic tw(input int k, input logic [63:0] d);
    @(negedge mclk);
    nested_on = k != 0;
    attr_write = k < 2;
    guest_entry_operation = k == 2;
    guest_exit_operation = k == 3;
    attr_write_data = d;
    control_block_attr = d;
    @(negedge mclk);
    {attr_write, guest_entry_operation, guest_exit_operation} = '0;
    chk(wc_flush, k > 1);
    repeat (2) @(negedge mclk);
    chk(wc_flush, 1'b0);
  endtask
  task automatic ent(input logic [2:0] g, n, r, input logic gc, hc, input nmtc_type_t e);
    @(negedge mclk);
    guest_entry_bits = g;
    nested_entry_bits = n;
    range_type_register = r;
    guest_cache_disable = gc;
    host_cache_disable = hc;
    guest_page_size = g[1:0];
    nested_page_size = n[1:0];
    entry_write = 1'b1;
    n_ent++;
    @(negedge mclk);
    entry_write = 1'b0;
    chk(entry_valid, 1'b1);
    chk(entry_type, e);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {nested_on, guest_entry_operation, guest_exit_operation, attr_write, rstn} = '0;
    {guest_cache_disable, host_cache_disable, entry_write, pdp_read_valid} = '0;
    {control_block_attr, attr_write_data, pdp_read_data, guest_page_size} = '0;
    {guest_entry_bits, nested_entry_bits, range_type_register, nested_page_size} = '0;
    {guest_base_bits, nested_base_bits, guest_leaf_is_table, nested_leaf_is_table} = '0;
    sys_addr = '1;
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;
    chk(page_attribute_table, ATTR_RESET);
    tw(0, TBL);
    chk(page_attribute_table, TBL);
    tw(2, 64'h0);
    chk(guest_attribute_table, 64'h0);
    $display("test tables done");
    nested_on = 1'b0;
    for (int i = 0; i < 6; i++)
      ent(3'(i), 3'(i), MT_WB, 1'b1, 1'b0, pr(ty[i], NMTC_WB, 1'b0));
    $display("test nested off done");
    // A nested-mode write of another value must leave the host table alone.
    tw(1, ATTR_RESET);
    chk(page_attribute_table, TBL);
    tw(1, TBL);
    chk(guest_attribute_table, TBL);
    tw(3, 64'h0);
    for (int c = 0; c < 3; c++)
      for (int g = 0; g < 6; g++)
        for (int n = 0; n < 6; n++)
          for (int r = 0; r < 5; r++)
            ent(3'(g), 3'(n), rc[r], c == 1, c == 2,
                pr(gh(ty[g], ty[n]), rt[r], c != 0));
    // Base bits must win over the entry bits, which would give WB here.
    guest_leaf_is_table = 1'b1;
    nested_leaf_is_table = 1'b1;
    guest_base_bits = 2'h2;
    nested_base_bits = 2'h3;
    ent(3'h5, 3'h5, MT_WB, 1'b0, 1'b0, pr(gh(ty[2], ty[3]), NMTC_WB, 1'b0));
    {guest_leaf_is_table, nested_leaf_is_table} = '0;
    $display("test merge done");
    for (int k = 0; k < 2; k++)
    begin
      @(negedge mclk);
      pdp_read_valid = 1'b1;
      pdp_read_data = k == 0 ? 64'h3 : 64'h1;
      @(negedge mclk);
      pdp_read_valid = 1'b0;
      chk(pdp_fault, k == 0);
    end
    $display("test walk done");
    chk(n_buf, n_ent);
    final_report;
  end
  initial
  begin
    repeat (3000) @(posedge mclk);
    error_cnt++;
    final_report;
  end
endmodule
`default_nettype wire
